// >>> design/bmsr_pkg.sv
// Purpose: shared constants and types of the buzzer and melody sound block
// Assumes: 32-bit APB, one word per register
// Notes: offsets are byte addresses
`default_nettype none
package bmsr_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CLK = 8'h00;
  localparam logic [7:0] OFF_SEL = 8'h04;
  localparam logic [7:0] OFF_CTL = 8'h08;
  localparam logic [7:0] OFF_DAT = 8'h0c;
  localparam logic [7:0] OFF_FLG = 8'h10;
  localparam logic [7:0] OFF_IEN = 8'h14;
  // ==========================================================
  // field positions
  localparam int CLK_DEBUG_RUN = 8;
  localparam int CLK_DIV_LSB = 4;
  localparam int CLK_SRC_LSB = 0;
  localparam int SEL_TIME_LSB = 8;
  localparam int SEL_DRIVE = 2;
  localparam int SEL_MODE_LSB = 0;
  localparam int CTL_STOP = 8;
  localparam int CTL_EN = 0;
  localparam int FLG_BUSY = 8;
  localparam int FLG_EMPTY = 1;
  localparam int FLG_DONE = 0;
  localparam int IEN_EMPTY = 1;
  localparam int IEN_DONE = 0;
  // ==========================================================
  // reset values and codes
  localparam logic [15:0] DAT_RESET = 16'h00ff;
  localparam logic EMPTY_RESET = 1'b1;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_MELODY = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_HIGH = 2'h2;
  localparam logic [2:0] DIV_MAX_CODE = 3'h5;
  localparam logic [2:0] DIV_ONE_CODE = 3'h7;
  // ==========================================================
  // timing: one time step is 15.625 ms of a 32768 Hz sound clock
  localparam longint UNIT_PS = 64'd15625000000;
  localparam longint SND_HZ = 64'd32768;
  localparam int UNIT_TICKS = int'(UNIT_PS * SND_HZ / 64'd1000000000000);
  localparam logic [4:0] GAP_TICKS = 5'h10;
  // ==========================================================
  // types
  typedef struct packed {
    logic tie;
    logic rest;
    logic [5:0] len;
    logic [7:0] frq;
  } bmsr_word_type;
  typedef struct packed {
    logic out_true;
    logic out_comp;
  } bmsr_pins_type;
  typedef enum logic {ST_IDLE, ST_PLAY} bmsr_state_type;
endpackage
`default_nettype wire

// >>> design/bmsr_sound.sv
// Purpose: buzzer and melody sound generator with APB registers
// Assumes: src_tick pulses mark source clock edges, synchronous to pclk
// Notes: pins drive a piezo buzzer as a complementary pair
// Overview of operation
// RULE1 - debug_run keeps sound clock in debug
// RULE2 - two-bit field selects sound clock source
// RULE3 - divider codes give 1/4 to 1/128, 1/1
// RULE4 - clock control writable only while disabled
// RULE5 - time field sets tempo or one-shot duration
// RULE6 - software leaves time field alone while busy
// RULE7 - drive mode bit picks normal or direct
// RULE8 - mode field picks normal, one-shot, melody
// RULE9 - stop bit ends output, reads pending
// RULE10 - stop forcibly ends one-shot and melody
// RULE11 - generator enable gates clock and operation
// RULE12 - data write fills buffer, starts output
// RULE13 - tie plays note joined to previous
// RULE14 - rest drives true low, complement high
// RULE15 - length field gives duration or duty
// RULE16 - buzzer modes use low six frequency bits
// RULE17 - byte writes to data are discarded
// RULE18 - busy bit shows output in progress
// RULE19 - empty flag resets set, data write clears
// RULE20 - done flag cleared by one or data write
// RULE21 - load or stop sets empty flag
// RULE22 - one-shot ends itself, sets done
// RULE23 - melody ends without new word, sets done
// RULE24 - interrupt only for enabled set flags
// RULE25 - reserved bits read zero, ignore writes
`timescale 1ns/1ns
`default_nettype none
module bmsr_sound #(
  parameter int ADDR_W = 8,
  parameter logic [3:0] SRC_PRESENT = 4'hf
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] src_tick,
  input wire logic debug_mode,
  output bmsr_pkg::bmsr_pins_type pins,
  output logic sound_irq
);
  // ==========================================================
  // elaboration checks
  if (ADDR_W < 5) begin : g_bad_addr
    $error("address width too small for register map");
  end

  // ==========================================================
  // state
  logic debug_run;
  logic [2:0] clock_divider_select;
  logic [1:0] clock_source_select;
  logic [3:0] tempo_duration_select;
  logic pin_drive_mode;
  logic [1:0] output_mode_select;
  logic generator_enable;
  logic stop_request;
  bmsr_pkg::bmsr_word_type data_buf;
  bmsr_pkg::bmsr_word_type cur;
  logic buf_full;
  logic buffer_empty_flag;
  logic output_done_flag;
  logic [1:0] irq_enable;
  bmsr_pkg::bmsr_state_type state;
  bmsr_pkg::bmsr_state_type next_state;
  logic [6:0] pre;
  logic [7:0] phase;
  logic [19:0] remain;
  logic [4:0] age;
  bmsr_pkg::bmsr_pins_type next_pins;

  // ==========================================================
  // apb decode
  wire [7:0] addr8 = 8'(paddr);
  wire wr = psel && penable && pwrite;
  wire full16 = pstrb[1:0] == 2'h3;
  wire hit_clk = addr8 == bmsr_pkg::OFF_CLK;
  wire hit_sel = addr8 == bmsr_pkg::OFF_SEL;
  wire hit_ctl = addr8 == bmsr_pkg::OFF_CTL;
  wire hit_dat = addr8 == bmsr_pkg::OFF_DAT;
  wire hit_flg = addr8 == bmsr_pkg::OFF_FLG;
  wire hit_ien = addr8 == bmsr_pkg::OFF_IEN;
  wire hit_any = hit_clk || hit_sel || hit_ctl || hit_dat || hit_flg || hit_ien;
  wire upper_ok = paddr[ADDR_W-1:0] == ADDR_W'(addr8);
  wire mapped = hit_any && upper_ok;
  // zero wait states; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================
  // clock control write check
  wire [2:0] w_div = pwdata[bmsr_pkg::CLK_DIV_LSB +: 3];
  wire [1:0] w_src = pwdata[bmsr_pkg::CLK_SRC_LSB +: 2];
  wire fast_src = w_src == bmsr_pkg::SRC_INT || w_src == bmsr_pkg::SRC_HIGH;
  // reserved divider codes and absent sources are refused
  wire div_ok = fast_src ? (w_div <= bmsr_pkg::DIV_MAX_CODE)
                         : (w_div == bmsr_pkg::DIV_ONE_CODE); // see RULE3
  wire src_ok = SRC_PRESENT[w_src]; // see RULE2
  // locked while the generator runs
  wire clk_wr = wr && mapped && hit_clk && full16 && !generator_enable
                && div_ok && src_ok; // see RULE4
  wire sel_wr = wr && mapped && hit_sel;
  wire ctl_wr = wr && mapped && hit_ctl;
  // only full halfword writes reach the sound buffer
  wire dat_wr = wr && mapped && hit_dat && full16; // see RULE17
  wire flg_wr = wr && mapped && hit_flg && pstrb[0];
  wire ien_wr = wr && mapped && hit_ien && pstrb[0];
  wire stop_wr = ctl_wr && pstrb[1] && pwdata[bmsr_pkg::CTL_STOP]; // see RULE9
  wire [1:0] w_mode = pwdata[bmsr_pkg::SEL_MODE_LSB +: 2];

  // ==========================================================
  // sound clock: source select, gating and prescaler
  wire clk_run = generator_enable && (!debug_mode || debug_run); // see RULE1, RULE11
  wire src_edge = clk_run && src_tick[clock_source_select]; // see RULE2
  wire [6:0] div_last = (clock_divider_select == bmsr_pkg::DIV_ONE_CODE) ? 7'h00
                      : 7'((8'h04 << clock_divider_select) - 8'h01); // see RULE3
  wire snd_tick = src_edge && pre == div_last;

  // ==========================================================
  // durations in sound clock ticks
  wire melody = output_mode_select == bmsr_pkg::MODE_MELODY;
  wire normal = output_mode_select == bmsr_pkg::MODE_NORMAL;
  wire oneshot = output_mode_select == bmsr_pkg::MODE_ONESHOT;
  wire playing = state == bmsr_pkg::ST_PLAY;
  wire [19:0] time_ticks = 20'((32'(tempo_duration_select) + 32'h1)
                               * 32'(bmsr_pkg::UNIT_TICKS)); // see RULE5
  wire [19:0] note_ticks = 20'(32'(time_ticks)
                               * (32'(data_buf.len) + 32'h1)); // see RULE15
  wire [19:0] load_ticks = melody ? note_ticks : time_ticks;

  // ==========================================================
  // sequencing events
  wire at_end = remain == 20'h1;
  // idle starts at once; normal mode takes a new word at once
  wire load_cond = buf_full && !stop_request
                   && (!playing || normal || (melody && at_end)); // see RULE12
  wire load = snd_tick && load_cond; // see RULE21
  wire expire = snd_tick && playing && !normal && at_end && !load; // see RULE22, RULE23
  // a stop is served on the next sound tick, or at once when disabled
  wire stop_now = stop_request && (snd_tick || !generator_enable); // see RULE9
  wire play_end = (stop_now && playing) || expire; // see RULE10

  // ==========================================================
  // waveform level
  wire [7:0] frq_eff = melody ? cur.frq : {2'h0, cur.frq[5:0]}; // see RULE16
  wire tone_hi = melody ? (phase <= (frq_eff >> 1))
                        : (phase <= {2'h0, cur.len}); // see RULE15
  // untied melody notes start with a short silent gap
  wire gap = melody && !cur.tie && age < bmsr_pkg::GAP_TICKS; // see RULE13
  wire lvl = tone_hi && !gap;

  // next pin levels, registered below
  always_comb begin
    next_pins.out_true = 1'b0;
    next_pins.out_comp = 1'b0;
    if (playing && melody && cur.rest) begin
      next_pins.out_comp = 1'b1; // see RULE14
    end else if (playing) begin
      next_pins.out_true = lvl;
      next_pins.out_comp = pin_drive_mode ? !lvl : 1'b0; // see RULE7
    end
  end

  // next sequencer state
  always_comb begin
    next_state = state;
    case (state)
      bmsr_pkg::ST_IDLE: begin
        if (load) begin
          next_state = bmsr_pkg::ST_PLAY;
        end
      end
      bmsr_pkg::ST_PLAY: begin
        if (play_end) begin
          next_state = bmsr_pkg::ST_IDLE;
        end
      end
      default: next_state = bmsr_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // clock control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_run <= 1'b0;
      clock_divider_select <= 3'h0;
      clock_source_select <= 2'h0;
    end else if (clk_wr) begin
      debug_run <= pwdata[bmsr_pkg::CLK_DEBUG_RUN];
      clock_divider_select <= w_div;
      clock_source_select <= w_src;
    end
  end

  // mode select register; the reserved mode code is refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tempo_duration_select <= 4'h0;
      pin_drive_mode <= 1'b0;
      output_mode_select <= bmsr_pkg::MODE_NORMAL;
    end else if (sel_wr) begin
      if (pstrb[1]) begin
        tempo_duration_select <= pwdata[bmsr_pkg::SEL_TIME_LSB +: 4]; // see RULE5
      end
      if (pstrb[0]) begin
        pin_drive_mode <= pwdata[bmsr_pkg::SEL_DRIVE];
        if (w_mode != bmsr_pkg::MODE_RSVD) begin
          output_mode_select <= w_mode; // see RULE8
        end
      end
    end
  end

  // enable bit and pending stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      generator_enable <= 1'b0;
      stop_request <= 1'b0;
    end else begin
      if (ctl_wr && pstrb[0]) begin
        generator_enable <= pwdata[bmsr_pkg::CTL_EN]; // see RULE11
      end
      if (stop_wr) begin
        stop_request <= 1'b1;
      end else if (stop_now) begin
        stop_request <= 1'b0; // see RULE9
      end
    end
  end

  // sound buffer and its occupancy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_buf <= bmsr_pkg::DAT_RESET;
      buf_full <= 1'b0;
    end else begin
      if (dat_wr) begin
        data_buf <= pwdata[15:0]; // see RULE12
      end
      if (dat_wr) begin
        buf_full <= 1'b1;
      end else if (load || stop_wr) begin
        buf_full <= 1'b0;
      end
    end
  end

  // flags: hardware set wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_empty_flag <= bmsr_pkg::EMPTY_RESET;
      output_done_flag <= 1'b0;
      irq_enable <= 2'h0;
    end else begin
      if (load || stop_wr) begin
        buffer_empty_flag <= 1'b1; // see RULE21
      end else if (dat_wr) begin
        buffer_empty_flag <= 1'b0; // see RULE19
      end
      if (play_end) begin
        output_done_flag <= 1'b1; // see RULE22, RULE23
      end else if (dat_wr || (flg_wr && pwdata[bmsr_pkg::FLG_DONE])) begin
        output_done_flag <= 1'b0; // see RULE20
      end
      if (ien_wr) begin
        irq_enable <= {pwdata[bmsr_pkg::IEN_EMPTY], pwdata[bmsr_pkg::IEN_DONE]};
      end
    end
  end

  // sequencer, prescaler and tone counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bmsr_pkg::ST_IDLE;
      cur <= bmsr_pkg::DAT_RESET;
      pre <= 7'h00;
      phase <= 8'h00;
      remain <= 20'h0;
      age <= 5'h00;
    end else begin
      state <= next_state;
      if (src_edge) begin
        pre <= (pre == div_last) ? 7'h00 : 7'(pre + 7'h01);
      end
      if (load) begin
        cur <= data_buf;
        phase <= 8'h00;
        remain <= load_ticks;
        age <= 5'h00;
      end else if (snd_tick && playing) begin
        phase <= (phase >= frq_eff) ? 8'h00 : 8'(phase + 8'h01);
        if (!normal && !at_end) begin
          remain <= 20'(remain - 20'h1);
        end
        if (age < bmsr_pkg::GAP_TICKS) begin
          age <= 5'(age + 5'h01);
        end
      end
    end
  end

  // pins, interrupt and read data are registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '0;
      sound_irq <= 1'b0;
    end else begin
      pins <= next_pins;
      sound_irq <= (buffer_empty_flag && irq_enable[1])
                   || (output_done_flag && irq_enable[0]); // see RULE24
    end
  end

  // ==========================================================
  // read mux; unused bits read as zero
  wire [15:0] rd_clk = 16'(({15'h0, debug_run} << bmsr_pkg::CLK_DEBUG_RUN)
                      | ({13'h0, clock_divider_select} << bmsr_pkg::CLK_DIV_LSB)
                      | {14'h0, clock_source_select}); // see RULE25
  wire [15:0] rd_sel = 16'(({12'h0, tempo_duration_select} << bmsr_pkg::SEL_TIME_LSB)
                      | ({15'h0, pin_drive_mode} << bmsr_pkg::SEL_DRIVE)
                      | {14'h0, output_mode_select});
  wire [15:0] rd_ctl = 16'(({15'h0, stop_request} << bmsr_pkg::CTL_STOP)
                      | {15'h0, generator_enable});
  wire [15:0] rd_flg = 16'(({15'h0, playing} << bmsr_pkg::FLG_BUSY) // see RULE18
                      | ({15'h0, buffer_empty_flag} << bmsr_pkg::FLG_EMPTY)
                      | {15'h0, output_done_flag});
  wire [15:0] rd_val = !upper_ok ? 16'h0000
                     : hit_clk ? rd_clk
                     : hit_sel ? rd_sel
                     : hit_ctl ? rd_ctl
                     : hit_dat ? data_buf
                     : hit_flg ? rd_flg
                     : hit_ien ? {14'h0, irq_enable} : 16'h0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {16'h0, rd_val};
    end
  end

  // ==========================================================
  // assertions
  a_clk_lock_held: assert property (@(posedge pclk) disable iff (!presetn) // see RULE4
    (wr && hit_clk && generator_enable) |=> $stable(clock_source_select)
      && $stable(clock_divider_select) && $stable(debug_run))
    else $error("clock control changed while enabled");
  a_debug_halt_held: assert property (@(posedge pclk) disable iff (!presetn) // see RULE1
    (debug_mode && !debug_run) |=> $stable(pre) && $stable(state))
    else $error("sound clock ran in debug halt");
  a_data_clears_empty: assert property (@(posedge pclk) disable iff (!presetn) // see RULE19
    (dat_wr && !load && !stop_wr) |=> !buffer_empty_flag)
    else $error("data write did not clear empty flag");
  a_byte_write_drop: assert property (@(posedge pclk) disable iff (!presetn) // see RULE17
    (wr && hit_dat && !full16 && !load && !stop_wr) |=> $stable(data_buf) && $stable(buf_full))
    else $error("byte write altered sound buffer");
  a_stop_sets_empty: assert property (@(posedge pclk) disable iff (!presetn) // see RULE21
    stop_wr |=> buffer_empty_flag && !buf_full && stop_request)
    else $error("stop did not set empty flag");
  a_end_sets_done: assert property (@(posedge pclk) disable iff (!presetn) // see RULE22
    play_end |=> output_done_flag && state == bmsr_pkg::ST_IDLE)
    else $error("end of output did not set done");
  a_irq_done_path: assert property (@(posedge pclk) disable iff (!presetn) // see RULE24
    (output_done_flag && irq_enable[0]) |=> sound_irq)
    else $error("enabled done flag gave no interrupt");
  a_rest_pin_pair: assert property (@(posedge pclk) disable iff (!presetn) // see RULE14
    (playing && melody && cur.rest) |=> !pins.out_true && pins.out_comp)
    else $error("rest pins wrong");
  a_oneshot_len_ok: assert property (@(posedge pclk) disable iff (!presetn) // see RULE5
    (load && oneshot) |=> remain == 20'(32'(tempo_duration_select + 5'h1) * 32'd512))
    else $error("one-shot duration wrong");
endmodule
`default_nettype wire

// >>> bench/bmsr_piezo.sv
// Purpose: piezo buzzer model on the complementary pin pair
// Assumes: pins are registered in the pclk domain
// Notes: counts rising edges of the true pin so tests see a tone
`timescale 1ns/1ns
`default_nettype none
module bmsr_piezo (
  input wire logic pclk,
  input wire logic presetn,
  input wire bmsr_pkg::bmsr_pins_type pins,
  output int edge_count
);
  logic last_true;
  // ==========================================================
  // tone edge counter, a silent pin or a rest adds nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_true <= 1'b0;
      edge_count <= 0;
    end else begin
      last_true <= pins.out_true;
      if (pins.out_true && !last_true) begin
        edge_count <= edge_count + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Purpose: self-checking bench of the sound block over APB
// Assumes: source ticks every second pclk, divider 1/4, so one sound tick per 8 cycles
// Notes: one time step is 512 sound ticks, 4096 cycles
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, debug_mode, sound_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [3:0] src_tick = 4'h0;
  bmsr_pkg::bmsr_pins_type pins;
  int n_fail, n_tests, tone, tone0;
  logic last_err;
  bmsr_sound i_bmsr_sound (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_tick(src_tick), .debug_mode(debug_mode),
    .pins(pins), .sound_irq(sound_irq));
  bmsr_piezo i_bmsr_piezo (.pclk(pclk), .presetn(presetn), .pins(pins), .edge_count(tone));
  // ==========================================================
  // clock and source ticks
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    src_tick <= ~src_tick;
  end
  // ==========================================================
  // compare, verdict and watchdog
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #600000;
    n_fail++;
    stop_test();
  end
  // ==========================================================
  // apb master: setup, access held until pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(r, exp);
  endtask
  // polls the flag register until a bit reaches a value
  task automatic wait_flag(input int idx, input logic v);
    int n;
    n = 0;
    apb(1'b0, bmsr_pkg::OFF_FLG, 32'h0, 4'h0);
    while (r[idx] !== v && n < 2000) begin
      n++;
      apb(1'b0, bmsr_pkg::OFF_FLG, 32'h0, 4'h0);
    end
    chk({31'h0, r[idx]}, {31'h0, v});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    n_fail = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    debug_mode = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and unmapped place
    rd_chk(bmsr_pkg::OFF_CLK, 32'h0000);
    rd_chk(bmsr_pkg::OFF_SEL, 32'h0000);
    rd_chk(bmsr_pkg::OFF_CTL, 32'h0000);
    rd_chk(bmsr_pkg::OFF_DAT, 32'h00ff);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0002);
    rd_chk(8'h40, 32'h0000);
    chk({31'h0, last_err}, 32'h1);
    // interrupt follows enabled empty flag
    wr(bmsr_pkg::OFF_IEN, 32'h2);
    @(negedge pclk);
    chk({31'h0, sound_irq}, 32'h1);
    @(posedge pclk);
    wr(bmsr_pkg::OFF_IEN, 32'h0);
    @(negedge pclk);
    chk({31'h0, sound_irq}, 32'h0);
    @(posedge pclk);
    // clock control: reserved divider, slow source, reserved bits
    wr(bmsr_pkg::OFF_CLK, 32'h0060);
    rd_chk(bmsr_pkg::OFF_CLK, 32'h0000);
    wr(bmsr_pkg::OFF_CLK, 32'h0071);
    rd_chk(bmsr_pkg::OFF_CLK, 32'h0071);
    wr(bmsr_pkg::OFF_CLK, 32'hffff);
    rd_chk(bmsr_pkg::OFF_CLK, 32'h0173);
    wr(bmsr_pkg::OFF_CLK, 32'h0000);
    // every mode code, reserved one keeps the old mode
    for (int m = 0; m < 4; m++) begin
      wr(bmsr_pkg::OFF_SEL, 32'hfff8 | m);
      rd_chk(bmsr_pkg::OFF_SEL, 32'h0f00 | ((m == 3) ? 2 : m));
    end
    wr(bmsr_pkg::OFF_SEL, 32'h0001);
    wr(bmsr_pkg::OFF_CTL, 32'h0001);
    wr(bmsr_pkg::OFF_CLK, 32'h0010);
    rd_chk(bmsr_pkg::OFF_CLK, 32'h0000);
    // byte write discarded, then debug halts the sound clock
    apb(1'b1, bmsr_pkg::OFF_DAT, 32'h0510, 4'h1);
    rd_chk(bmsr_pkg::OFF_DAT, 32'h00ff);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0002);
    debug_mode <= 1'b1;
    wr(bmsr_pkg::OFF_DAT, 32'h0510);
    repeat (100) @(posedge pclk);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0000);
    debug_mode <= 1'b0;
    // one-shot of one time step: 4096 cycles
    wait_flag(bmsr_pkg::FLG_BUSY, 1'b1);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0102);
    repeat (3790) @(posedge pclk);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0102);
    repeat (400) @(posedge pclk);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0003);
    wr(bmsr_pkg::OFF_FLG, 32'h0001);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0002);
    // melody rest in normal drive, ends with no new word
    wr(bmsr_pkg::OFF_SEL, 32'h0006);
    wr(bmsr_pkg::OFF_DAT, 32'h4000);
    wait_flag(bmsr_pkg::FLG_BUSY, 1'b1);
    repeat (300) @(posedge pclk);
    @(negedge pclk);
    chk({30'h0, pins}, 32'h1);
    @(posedge pclk);
    wait_flag(bmsr_pkg::FLG_BUSY, 1'b0);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0003);
    // normal buzzer runs until a stop request
    wr(bmsr_pkg::OFF_SEL, 32'h0004);
    wr(bmsr_pkg::OFF_DAT, 32'h0810);
    wait_flag(bmsr_pkg::FLG_BUSY, 1'b1);
    tone0 = tone;
    repeat (6000) @(posedge pclk);
    // tone period is frq + 1 = 17 sound ticks, 136 cycles
    chk({31'h0, (tone - tone0) inside {[43:45]}}, 32'h1);
    @(negedge pclk);
    chk({31'h0, pins.out_true ^ pins.out_comp}, 32'h1);
    @(posedge pclk);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0102);
    wr(bmsr_pkg::OFF_CTL, 32'h0101);
    wait_flag(bmsr_pkg::FLG_BUSY, 1'b0);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0003);
    rd_chk(bmsr_pkg::OFF_CTL, 32'h0001);
    // long one-shot in direct drive, cut short by a stop
    wr(bmsr_pkg::OFF_SEL, 32'h0f01);
    wr(bmsr_pkg::OFF_DAT, 32'h0810);
    wait_flag(bmsr_pkg::FLG_BUSY, 1'b1);
    @(negedge pclk);
    chk({31'h0, pins.out_comp}, 32'h0);
    @(posedge pclk);
    wr(bmsr_pkg::OFF_CTL, 32'h0101);
    wait_flag(bmsr_pkg::FLG_BUSY, 1'b0);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0003);
    // disabled generator never loads, stop still refills empty
    wr(bmsr_pkg::OFF_CTL, 32'h0000);
    wr(bmsr_pkg::OFF_DAT, 32'h0810);
    repeat (200) @(posedge pclk);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0000);
    wr(bmsr_pkg::OFF_CTL, 32'h0100);
    repeat (10) @(posedge pclk);
    rd_chk(bmsr_pkg::OFF_FLG, 32'h0002);
    stop_test();
  end
endmodule
`default_nettype wire
